// ---- src/wdog_sup_pkg.sv ----
/*
  Shared constants and types for the supervisor watchdog output block.
  Assumes a 200 MHz clock and a classic Wishbone register master.
*/
package wdog_sup_pkg;

  // ----------------------------------------------------------------------
  // time base
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned CYC_PER_TICK = TICK_US * CLK_MHZ;

  // ----------------------------------------------------------------------
  // intervals, in milliseconds (one tick each)
  // ----------------------------------------------------------------------
  localparam int unsigned GRACE_MS = 10000;
  localparam int unsigned BASE_MS = 20;
  localparam int unsigned HOLD_MS = 200;
  localparam int unsigned MAX_MS = 640000;
  localparam int unsigned SCALE_A = 1;

  // ----------------------------------------------------------------------
  // register map (byte addresses) and fields
  // ----------------------------------------------------------------------
  localparam logic [3:0] CTRL_ADDR = 4'h0;
  localparam logic [3:0] STATUS_ADDR = 4'h4;
  localparam logic [3:0] TMO_ADDR = 4'h8;
  localparam int unsigned CTRL_KICK_BIT = 0;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // input synchroniser: {uv, enable, sel_hi, sel_lo, man_rst_n, kick}
  // ----------------------------------------------------------------------
  localparam int unsigned N_SYNC = 6;
  localparam logic [5:0] SYNC_RST = 6'h03;

  typedef enum logic [4:0] {
    ST_WAIT  = 5'h01,
    ST_GRACE = 5'h02,
    ST_MON   = 5'h04,
    ST_OFF   = 5'h08,
    ST_FAULT = 5'h10
  } wd_state_e;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [31:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_s;

endpackage : wdog_sup_pkg

// ---- src/wdog_sup.sv ----
/*
  Watchdog, startup grace interval, manual reset and output priority
  logic of a supply supervisor, with a Wishbone register slave.
  Assumes the undervoltage flag arrives already filtered with hysteresis
  and that all pins are asynchronous to clk_i.
*/
// The implementer's own choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps

module wdog_sup #(
  parameter int unsigned CYC_PER_TICK = wdog_sup_pkg::CYC_PER_TICK,
  parameter int unsigned GRACE_MS = wdog_sup_pkg::GRACE_MS,
  parameter int unsigned BASE_MS = wdog_sup_pkg::BASE_MS,
  parameter int unsigned HOLD_MS = wdog_sup_pkg::HOLD_MS,
  parameter int unsigned SCALE = wdog_sup_pkg::SCALE_A,
  parameter int unsigned SEL_PINS = 2,
  parameter bit HAS_EN_PIN = 1'b0,
  parameter bit HAS_FAULT_OUT = 1'b1,
  parameter bit LATCHED = 1'b0,
  parameter bit CAP_TIMEOUT = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire wdog_sup_pkg::wb_req_s wb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic kick_i,
  input wire logic man_rst_n_i,
  input wire logic timeout_select_low_i,
  input wire logic timeout_select_high_i,
  input wire logic wd_enable_i,
  input wire logic uv_i,
  output logic reset_n_o,
  output logic watchdog_fault_n_o
);

  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  if (SEL_PINS < 1 || SEL_PINS > 2) begin : g_bad_sel
    $error("SEL_PINS must be 1 or 2");
  end
  if (SCALE < 1 || SCALE > 7 || CYC_PER_TICK < 1) begin : g_bad_scale
    $error("SCALE must be 1..7 and CYC_PER_TICK nonzero");
  end
  if (CAP_TIMEOUT && GRACE_MS != 0 && GRACE_MS != 10000) begin : g_bad_gr
    $error("capacitor timeout allows grace of 0 or 10000 ms only");
  end

  localparam logic [31:0] MAX_MS = 32'(wdog_sup_pkg::MAX_MS);
  localparam logic [31:0] TICK_LAST = 32'(CYC_PER_TICK - 1);
  localparam logic [31:0] GRACE_LIM = 32'(GRACE_MS);
  localparam logic [31:0] HOLD_LIM = 32'(HOLD_MS);

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  localparam int unsigned NS = wdog_sup_pkg::N_SYNC;
  logic [NS-1:0] raw;
  logic [NS-1:0] s1_q;
  logic [NS-1:0] s2_q;
  logic [NS-1:0] s3_q;
  logic [NS-1:0] flt_q;

  assign raw = {uv_i, wd_enable_i, timeout_select_high_i,
                timeout_select_low_i, man_rst_n_i, kick_i};

  // a change counts only once stages two and three agree
  for (genvar b = 0; b < NS; b++) begin : g_sync
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        s1_q[b] <= wdog_sup_pkg::SYNC_RST[b];
        s2_q[b] <= wdog_sup_pkg::SYNC_RST[b];
        s3_q[b] <= wdog_sup_pkg::SYNC_RST[b];
        flt_q[b] <= wdog_sup_pkg::SYNC_RST[b];
      end else if (ce_i) begin
        s1_q[b] <= raw[b];
        s2_q[b] <= s1_q[b];
        s3_q[b] <= s2_q[b];
        if (s2_q[b] == s3_q[b]) begin
          flt_q[b] <= s3_q[b];
        end
      end
    end
  end

  wire kick_f = flt_q[0];
  wire man_rst_n_f = flt_q[1];
  wire [1:0] sel_f = flt_q[3:2];
  wire en_f = flt_q[4];
  wire uv_f = flt_q[5];

  // ----------------------------------------------------------------------
  // timeout decode
  // ----------------------------------------------------------------------
  function automatic logic [31:0] tmo_calc(input logic [1:0] s);
    logic [4:0] sh;
    logic [63:0] v;
    sh = 5'h00;
    if (SEL_PINS == 1) begin
      sh = s[0] ? 5'(SCALE) : 5'h00;
    end else begin
      unique case (s)
        2'h2: sh = 5'(SCALE);
        2'h3: sh = 5'(SCALE + 1);
        default: sh = 5'h00; // 01 off, or same as 00 with a pin
      endcase
    end
    v = {32'h0000_0000, 32'(BASE_MS)} << sh;
    tmo_calc = (v > {32'h0000_0000, MAX_MS}) ? MAX_MS : v[31:0];
  endfunction : tmo_calc

  logic [31:0] tmo_new;
  logic wd_on;
  assign tmo_new = tmo_calc(sel_f);
  // enable pin alone rules when present
  assign wd_on = HAS_EN_PIN ? en_f : !(SEL_PINS == 2 && sel_f == 2'h1);

  // ----------------------------------------------------------------------
  // time base and register slave
  // ----------------------------------------------------------------------
  logic [31:0] pre_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic kick_prev_q;
  wire tick = (pre_q == TICK_LAST);

  wire wb_hit = wb_i.cyc & wb_i.stb & ~ack_q;
  wire wb_map = (wb_i.adr[31:4] == 28'h0000000);
  wire [3:0] wb_off = {wb_i.adr[3:2], 2'b00};
  wire soft_kick = wb_i.cyc & wb_i.stb & ack_q & wb_i.we & wb_map &
                   wb_i.sel[0] & (wb_off == wdog_sup_pkg::CTRL_ADDR) &
                   wb_i.dat[wdog_sup_pkg::CTRL_KICK_BIT];
  // pin falling edge, or register kick at its acked edge, counts
  wire kick_ev = (kick_prev_q & ~kick_f) | soft_kick;

  localparam wdog_sup_pkg::wd_state_e ST_WAIT = wdog_sup_pkg::ST_WAIT;
  localparam wdog_sup_pkg::wd_state_e ST_GRACE = wdog_sup_pkg::ST_GRACE;
  localparam wdog_sup_pkg::wd_state_e ST_MON = wdog_sup_pkg::ST_MON;
  localparam wdog_sup_pkg::wd_state_e ST_OFF = wdog_sup_pkg::ST_OFF;
  localparam wdog_sup_pkg::wd_state_e ST_FAULT = wdog_sup_pkg::ST_FAULT;
  wdog_sup_pkg::wd_state_e st_q;
  wdog_sup_pkg::wd_state_e st_d;
  logic rst_act_q;
  logic rst_act_d;
  logic rst_n_q;
  logic wdo_n_q;
  logic [31:0] tmo_q;

  wire [31:0] status = {24'h000000, wd_on, st_q, ~wdo_n_q, ~rst_n_q};
  logic [31:0] rdat_d;
  always_comb begin
    rdat_d = wdog_sup_pkg::RD_ZERO;
    if (wb_map) begin
      unique case (wb_off)
        wdog_sup_pkg::STATUS_ADDR: rdat_d = status;
        wdog_sup_pkg::TMO_ADDR: rdat_d = tmo_q;
        default: rdat_d = wdog_sup_pkg::RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_q <= 32'h0000_0000;
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
      kick_prev_q <= 1'b1;
    end else if (ce_i) begin
      pre_q <= tick ? 32'h0000_0000 : pre_q + 32'h0000_0001;
      ack_q <= wb_hit;
      rdat_q <= rdat_d;
      kick_prev_q <= kick_f;
    end
  end

  // ----------------------------------------------------------------------
  // reset output cause and hold
  // ----------------------------------------------------------------------
  logic [31:0] rhold_q;
  logic [31:0] rhold_d;
  wire rst_cause = uv_f | ~man_rst_n_f;

  always_comb begin
    rst_act_d = rst_act_q;
    rhold_d = rhold_q;
    if (rst_cause) begin
      rst_act_d = 1'b1;
      rhold_d = 32'h0000_0000;
    end else if (rst_act_q) begin
      if (LATCHED || rhold_q >= HOLD_LIM) begin
        rst_act_d = 1'b0; // latch frees at hold end, or once its cause clears when LATCHED
      end else if (tick) begin
        rhold_d = rhold_q + 32'h0000_0001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // watchdog sequencer
  // ----------------------------------------------------------------------
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic [31:0] tmo_d;
  wire [31:0] cnt_inc = tick ? cnt_q + 32'h0000_0001 : cnt_q;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_inc;
    tmo_d = tmo_q;
    if (rst_act_d) begin
      st_d = ST_WAIT; // reset drops any fault and parks the dog
      cnt_d = 32'h0000_0000;
    end else begin
      unique case (st_q)
        ST_WAIT: begin
          st_d = wd_on ? ST_GRACE : ST_OFF;
          cnt_d = 32'h0000_0000;
        end
        ST_GRACE: begin
          if (!wd_on) begin
            st_d = ST_OFF;
            cnt_d = 32'h0000_0000;
          end else if (kick_ev) begin
            st_d = ST_MON;
            cnt_d = 32'h0000_0000;
            tmo_d = tmo_new;
          end else if (cnt_q >= GRACE_LIM) begin
            st_d = ST_FAULT;
            cnt_d = 32'h0000_0000;
          end
        end
        ST_MON: begin
          if (!wd_on) begin
            st_d = ST_OFF;
            cnt_d = 32'h0000_0000;
          end else if (kick_ev || tmo_new != tmo_q) begin
            cnt_d = 32'h0000_0000;
            tmo_d = tmo_new;
          end else if (cnt_q >= tmo_q) begin
            st_d = ST_FAULT;
            cnt_d = 32'h0000_0000;
          end
        end
        ST_OFF: begin
          cnt_d = 32'h0000_0000;
          if (wd_on) begin
            st_d = ST_MON; // straight to a window, no grace
            tmo_d = tmo_new;
          end
        end
        ST_FAULT: begin
          if (!wd_on) begin
            st_d = ST_OFF; // a disabled dog shows no fault
          end else if (LATCHED ? kick_ev : (cnt_q >= HOLD_LIM)) begin
            st_d = ST_GRACE;
            cnt_d = 32'h0000_0000;
          end
        end
        default: begin
          st_d = ST_WAIT;
          cnt_d = 32'h0000_0000;
        end
      endcase
    end
  end

  // fault shares the reset pin when there is no separate one
  wire fault_d = (st_d == ST_FAULT);
  wire rst_n_d = ~(rst_act_d | (fault_d & ~HAS_FAULT_OUT));
  wire wdo_n_d = ~(fault_d & HAS_FAULT_OUT);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= ST_WAIT;
      cnt_q <= 32'h0000_0000;
      tmo_q <= 32'(BASE_MS);
      rst_act_q <= 1'b1; // power-up holds reset for the hold time, or for one clock when LATCHED
      rhold_q <= 32'h0000_0000;
      rst_n_q <= 1'b0;
      wdo_n_q <= 1'b1;
    end else if (ce_i) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      tmo_q <= tmo_d;
      rst_act_q <= rst_act_d;
      rhold_q <= rhold_d;
      rst_n_q <= rst_n_d;
      wdo_n_q <= wdo_n_d;
    end
  end

  assign reset_n_o = rst_n_q;
  assign watchdog_fault_n_o = wdo_n_q;
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_GRACE_AFTER_RESET: assert property (
    ce_i && rst_act_q && !rst_cause && rhold_q >= HOLD_LIM && wd_on
    |=> st_q == ST_GRACE && rst_n_q)
    else $error("grace did not start after reset ended");
  AST_NO_FAULT_IN_GRACE: assert property (
    st_q == ST_GRACE |-> wdo_n_q && (rst_n_q == !rst_act_q))
    else $error("output asserted during grace");
  AST_KICK_ENDS_GRACE: assert property (
    ce_i && st_q == ST_GRACE && kick_ev && wd_on && !rst_cause
    |=> st_q == ST_MON && cnt_q == 32'h0 && tmo_q == $past(tmo_new))
    else $error("kick did not end grace");
  AST_GRACE_EXPIRY: assert property (
    ce_i && st_q == ST_GRACE && cnt_q >= GRACE_LIM && !kick_ev && wd_on
    && !rst_cause |=> st_q == ST_FAULT && (!wdo_n_q || !rst_n_q))
    else $error("grace expiry raised no fault");
  AST_ENABLE_NO_GRACE: assert property (
    ce_i && st_q == ST_OFF |=> st_q != ST_GRACE)
    else $error("enable started a grace interval");
  AST_TIMEOUT_CLAMP: assert property (
    tmo_q <= MAX_MS && tmo_q != 32'h0)
    else $error("timeout outside range");
  AST_MANUAL_RESET: assert property (
    ce_i && !man_rst_n_f |=> !rst_n_q && wdo_n_q)
    else $error("manual reset did not assert reset");
  AST_RESET_WINS: assert property (
    !rst_n_q && rst_act_q |-> wdo_n_q && st_q == ST_WAIT)
    else $error("fault output asserted under reset");
  AST_KICK_RESTART: assert property (
    ce_i && st_q == ST_MON && kick_ev && wd_on && !rst_cause
    |=> cnt_q == 32'h0 && st_q == ST_MON)
    else $error("kick did not restart window");
  AST_DISABLE_ABORTS: assert property (
    ce_i && !wd_on && !rst_cause && !rst_act_q && st_q == ST_MON
    |=> st_q == ST_OFF ##1 wdo_n_q)
    else $error("disable did not abort window");
  AST_HOLD_TIME: assert property (
    ce_i && rst_act_q && !rst_cause && rhold_q < HOLD_LIM && !LATCHED
    |=> rst_act_q && !rst_n_q)
    else $error("reset released before hold time");
  AST_WB_ACK: assert property (
    ce_i && wb_i.cyc && wb_i.stb && !ack_q |=> ack_q)
    else $error("bus access not acknowledged");
endmodule : wdog_sup

// ---- verification/wdog_host_model.sv ----
/*
  Host model: drives the kick pin and the two timeout select pins.
  Assumes the bench clock; every pin changes just after a rising edge.
*/
`timescale 1ns/1ps
module wdog_host_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [7:0] period_i,
  input wire logic [1:0] code_i,
  output logic kick_o,
  output logic sel_lo_o,
  output logic sel_hi_o
);
  logic [7:0] cnt_q;

  // ----------------------------------------------------------------------
  // kick: one falling edge per period while running, idle high
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      cnt_q <= 8'h00;
      kick_o <= 1'b1;
    end else begin
      cnt_q <= (cnt_q + 8'h01 >= period_i) ? 8'h00 : cnt_q + 8'h01;
      kick_o <= (cnt_q < (period_i >> 1));
    end
  end

  // half period must outlast the pin filter, so keep period_i >= 10
  always_ff @(posedge clk_i) begin
    sel_lo_o <= code_i[0];
    sel_hi_o <= code_i[1];
  end
endmodule : wdog_host_model

// ---- verification/watchdog_supervisor_outputs_bench.sv ----
/*
  Self-checking bench for the supervisor watchdog block.
  Assumes shortened counts: 4 clocks a tick, grace 20, hold 5, base 8.
*/
`timescale 1ns/1ps
module watchdog_supervisor_outputs_bench;
  localparam int TICK = 4;
  localparam int HC = 5 * TICK;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  wdog_sup_pkg::wb_req_s wb_q = '0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, kick, sel_lo, sel_hi, reset_n_o, watchdog_fault_n_o;
  logic man_rst_n = 1'b1;
  logic ce = 1'b1;
  logic en = 1'b0;
  logic [7:0] period = 8'h14;
  logic fault_en_n;
  wdog_sup_pkg::wb_req_s wb_idle = '0;
  logic uv = 1'b0;
  logic run = 1'b0;
  logic [1:0] code = 2'b00;
  logic [31:0] d;
  int fail_count = 0;
  int checks = 0;
  int cyc_n = 0;
  int n;

  always #2.5 clk_i = ~clk_i;

  wdog_sup #(.CYC_PER_TICK(TICK), .GRACE_MS(20), .HOLD_MS(5),
    .BASE_MS(8)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_i(wb_q),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .kick_i(kick),
    .man_rst_n_i(man_rst_n), .timeout_select_low_i(sel_lo),
    .timeout_select_high_i(sel_hi), .wd_enable_i(en), .uv_i(uv),
    .reset_n_o(reset_n_o), .watchdog_fault_n_o(watchdog_fault_n_o));

  // enable-pin variant: the pin alone gates the dog, code 01 acts as 00
  wdog_sup #(.CYC_PER_TICK(TICK), .GRACE_MS(20), .HOLD_MS(5),
    .BASE_MS(8), .HAS_EN_PIN(1'b1)) dut_en (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_i(wb_idle),
    .wb_dat_o(), .wb_ack_o(), .kick_i(kick),
    .man_rst_n_i(man_rst_n), .timeout_select_low_i(sel_lo),
    .timeout_select_high_i(sel_hi), .wd_enable_i(en), .uv_i(uv),
    .reset_n_o(), .watchdog_fault_n_o(fault_en_n));

  wdog_host_model host (
    .clk_i(clk_i), .rst_i(rst_i), .run_i(run), .period_i(period),
    .code_i(code), .kick_o(kick), .sel_lo_o(sel_lo), .sel_hi_o(sel_hi));

  // ----------------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 6000) begin
      fail_count++;
      close_out();
    end
  end

  // ----------------------------------------------------------------------
  // bus and pin helpers
  // ----------------------------------------------------------------------
  // waits for ack without assuming a latency; the cycle ceiling ends hangs
  task automatic wb(input logic we, input logic [31:0] adr, dat);
    @(posedge clk_i);
    wb_q <= '{cyc:1'b1, stb:1'b1, we:we, adr:adr, sel:4'hF, dat:dat};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    d = wb_dat_o;
    wb_q <= '0;
  endtask : wb

  task automatic state_is(input logic [4:0] e);
    wb(1'b0, 32'h4, 32'h0);
    chk({27'h0, d[6:2]}, {27'h0, e});
  endtask : state_is

  task automatic wait_sig(input bit f, input logic lvl, input int lim);
    n = 0;
    while (((f ? watchdog_fault_n_o : reset_n_o) !== lvl) && n < lim) begin
      @(posedge clk_i);
      n++;
    end
  endtask : wait_sig

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(reset_n_o, 1'b0);
    wait_sig(0, 1'b1, 200);
    chk(32'(n >= HC - 1), 32'h1);
    state_is(5'h02);
    chk(d[7], 1'b1);
    $display("test reset done");

    wait_sig(1, 1'b0, 300);
    chk(32'(n >= 65), 32'h1);
    chk(32'(n < 100), 32'h1);
    chk(reset_n_o, 1'b1);
    chk(fault_en_n, 1'b1);
    wait_sig(1, 1'b1, 100);
    chk(32'(n >= HC - 2 && n < 40), 32'h1);
    state_is(5'h02);
    $display("test grace expiry done");

    wb(1'b1, 32'h0, 32'h1);
    state_is(5'h04);
    run <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      code <= (i == 0) ? 2'b11 : ((i == 1) ? 2'b10 : 2'b00);
      repeat (12) @(posedge clk_i);
      wb(1'b0, 32'h8, 32'h0);
      chk(d, 32'h20 >> i);
      chk(watchdog_fault_n_o, 1'b1);
    end
    $display("test select codes done");

    code <= 2'b01;
    repeat (12) @(posedge clk_i);
    state_is(5'h08);
    chk(d[7], 1'b0);
    run <= 1'b0;
    en <= 1'b1;
    n = 0;
    while (fault_en_n !== 1'b0 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    chk(32'(n > 30 && n < 50), 32'h1);
    en <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk(fault_en_n, 1'b1);
    repeat (150) @(posedge clk_i);
    chk(watchdog_fault_n_o, 1'b1);
    code <= 2'b00;
    repeat (8) @(posedge clk_i);
    state_is(5'h04);
    wait_sig(1, 1'b0, 100);
    chk(32'(n > 5 && n < 60), 32'h1);
    $display("test disable done");

    man_rst_n <= 1'b0;
    wait_sig(0, 1'b0, 20);
    chk(32'(n < 12), 32'h1);
    repeat (2) @(posedge clk_i);
    chk(watchdog_fault_n_o, 1'b1);
    repeat (40) @(posedge clk_i);
    chk(reset_n_o, 1'b0);
    man_rst_n <= 1'b1;
    wait_sig(0, 1'b1, 100);
    chk(32'(n >= HC && n < 40), 32'h1);
    state_is(5'h02);
    $display("test manual reset done");

    uv <= 1'b1;
    wait_sig(0, 1'b0, 20);
    chk(32'(n < 12), 32'h1);
    chk(watchdog_fault_n_o, 1'b1);
    uv <= 1'b0;
    wait_sig(0, 1'b1, 100);
    chk(32'(n >= HC), 32'h1);
    $display("test undervoltage done");

    wb(1'b1, 32'hC, 32'hFFFF_FFFF);
    wb(1'b0, 32'hC, 32'h0);
    chk(d, 32'h0);
    wb(1'b0, 32'h10, 32'h0);
    chk(d, 32'h0);
    $display("test unmapped done");
    close_out();
  end
endmodule : watchdog_supervisor_outputs_bench
